// *** logic/bwr_pkg.sv ***
/*
  constants and types for the self-test, soft reset and wakeup registers.
  assumes a 32-bit axi4-lite master and a byte stream from the receive mac.
*/
package bwr_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam int ADDR_W = 8;
  localparam int IDX_SELFTEST = 32'h0000_0024;
  localparam int IDX_RESET_CTRL = 32'h0000_0026;
  localparam int IDX_WAKE_CTRL = 32'h0000_002a;
  localparam int IDX_CRC0_LOW = 32'h0000_0030;
  localparam int IDX_CRC0_HIGH = 32'h0000_0032;
  localparam int IDX_MASK0 = 32'h0000_0034;
  localparam int IDX_MASK_STEP = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] ADDR_SELFTEST = ADDR_W'(IDX_SELFTEST * 4);
  localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = ADDR_W'(IDX_RESET_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_WAKE_CTRL = ADDR_W'(IDX_WAKE_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CRC0_LOW = ADDR_W'(IDX_CRC0_LOW * 4);
  localparam logic [ADDR_W-1:0] ADDR_CRC0_HIGH = ADDR_W'(IDX_CRC0_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_MASK0 = ADDR_W'(IDX_MASK0 * 4);
  localparam logic [ADDR_W-1:0] ADDR_MASK_STEP = ADDR_W'(IDX_MASK_STEP * 4);

  // ==========================================================
  // field positions
  localparam int TX_DONE_BIT = 12;
  localparam int TX_FAIL_BIT = 11;
  localparam int TX_CNT_LSB = 8;
  localparam int RX_DONE_BIT = 4;
  localparam int RX_FAIL_BIT = 3;
  localparam int RX_CNT_LSB = 0;
  localparam int CNT_W = 3;
  localparam int QM_RESET_BIT = 1;
  localparam int GLOBAL_RESET_BIT = 0;
  localparam int MAGIC_ENABLE_BIT = 7;
  localparam int WAKE_PATTERNS = 4;
  localparam int MASK_WORDS = 4;
  localparam int MASK_WORD_BYTES = 16;
  localparam int PATTERN_BYTES = MASK_WORDS * MASK_WORD_BYTES;

  // ==========================================================
  // reset values and writable bits
  localparam logic [15:0] SELFTEST_DEFAULT = 16'h0000;
  localparam logic [15:0] RESET_CTRL_DEFAULT = 16'h0000;
  localparam logic [15:0] WAKE_CTRL_DEFAULT = 16'h0000;
  localparam logic [15:0] CRC_DEFAULT = 16'h0000;
  localparam logic [15:0] MASK_DEFAULT = 16'h0000;
  localparam logic [15:0] RESET_CTRL_WMASK = 16'h0003;
  localparam logic [15:0] WAKE_CTRL_WMASK = 16'h008f;
  localparam logic [15:0] FULL_WMASK = 16'hffff;

  // ==========================================================
  // bus answers and crc
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic done;
    logic failed;
    logic [CNT_W-1:0] fail_count;
  } bwr_selftest_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } bwr_rx_byte_t;

endpackage

// *** logic/bwr_wake_match.sv ***
/*
  wakeup frame 0 matcher: crc over the masked first 64 bytes of a frame.
  assumes one received byte per valid cycle, last flags the final byte.
*/
`timescale 1ns/1ps
module bwr_wake_match
  import bwr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic enable,
  input wire bwr_rx_byte_t rx,
  input wire logic [PATTERN_BYTES-1:0] byte_mask,
  input wire logic [31:0] expected_crc,
  output logic wake_event
);

  // ==========================================================
  // crc step, reflected ethernet polynomial
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  logic [6:0] byte_idx;
  logic [31:0] crc;
  logic [6:0] next_byte_idx;
  logic [31:0] next_crc;
  logic next_wake_event;
  logic [31:0] crc_upd;
  logic selected;

  // ==========================================================
  // byte walk
  always_comb
  begin
    selected = (byte_idx < 7'(PATTERN_BYTES)) &&
               byte_mask[byte_idx[5:0]];
    crc_upd = selected ? crc_byte(crc, rx.data) : crc;
    next_byte_idx = byte_idx;
    next_crc = crc;
    next_wake_event = 1'b0;
    if (clear || !enable)
    begin
      next_byte_idx = 7'h00;
      next_crc = CRC_INIT;
    end
    else if (rx.valid)
    begin
      if (rx.last)
      begin
        next_wake_event = (~crc_upd == expected_crc);
        next_byte_idx = 7'h00;
        next_crc = CRC_INIT;
      end
      else
      begin
        if (byte_idx < 7'(PATTERN_BYTES))
          next_byte_idx = byte_idx + 7'h01;
        next_crc = crc_upd;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      byte_idx <= 7'h00;
      crc <= CRC_INIT;
      wake_event <= 1'b0;
    end
    else
    begin
      byte_idx <= next_byte_idx;
      crc <= next_crc;
      wake_event <= next_wake_event;
    end
  end

  // ==========================================================
  // checks
  chk_wake_needs_enable:
    assert property (@(posedge aclk) disable iff (!aresetn)
      wake_event |-> $past(enable) && $past(rx.valid && rx.last))
    else $error("wake event without enabled frame end");

endmodule

// *** logic/bwr_regs.sv ***
/*
  axi4-lite register bank: memory self-test status, soft resets,
  wakeup detector enables, wakeup frame 0 crc and byte masks.
  assumes self-test results and the rx byte stream share aclk.
*/
`timescale 1ns/1ps
module bwr_regs
  import bwr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bwr_selftest_t tx_selftest,
  input wire bwr_selftest_t rx_selftest,
  input wire bwr_rx_byte_t rx_byte,
  output logic queue_manager_reset,
  output logic global_soft_reset,
  output logic magic_packet_detect_enable,
  output logic [WAKE_PATTERNS-1:0] wake_pattern_enable,
  output logic wake_pattern0_event
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [15:0] wmask);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = data[7:0];
    if (strb[1])
      r[15:8] = data[15:8];
    return (r & wmask) | (old & ~wmask);
  endfunction

  function automatic logic [ADDR_W-1:0] mask_addr(input int k);
    return ADDR_W'(ADDR_MASK0 + ADDR_W'(k) * ADDR_MASK_STEP);
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic h;
    h = (a == ADDR_SELFTEST) || (a == ADDR_RESET_CTRL) ||
        (a == ADDR_WAKE_CTRL) || (a == ADDR_CRC0_LOW) ||
        (a == ADDR_CRC0_HIGH);
    for (int k = 0; k < MASK_WORDS; k++)
    begin
      if (a == mask_addr(k))
        h = 1'b1;
    end
    return h;
  endfunction

  // ==========================================================
  // bus slave state
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] rdata;
  logic [1:0] rresp, bresp;
  logic bvalid, rvalid;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_rresp, next_bresp;
  logic wr_fire, rd_fire;
  logic [15:0] rd_value;

  // ==========================================================
  // register state
  logic [15:0] selftest, reset_ctrl, wake_ctrl, crc_low, crc_high;
  logic [15:0] mask [MASK_WORDS];
  logic [15:0] next_selftest, next_reset_ctrl, next_wake_ctrl;
  logic [15:0] next_crc_low, next_crc_high;
  logic [15:0] next_mask [MASK_WORDS];
  logic global_active;
  logic [PATTERN_BYTES-1:0] mask_flat;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign rd_fire = s_axi_arvalid && !rvalid;

  // ==========================================================
  // write and read channels
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rd_value};
      next_rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_comb
  begin
    rd_value = 16'h0000;
    case (s_axi_araddr)
      ADDR_SELFTEST: rd_value = selftest;
      ADDR_RESET_CTRL: rd_value = reset_ctrl;
      ADDR_WAKE_CTRL: rd_value = wake_ctrl;
      ADDR_CRC0_LOW: rd_value = crc_low;
      ADDR_CRC0_HIGH: rd_value = crc_high;
      default: rd_value = 16'h0000;
    endcase
    for (int k = 0; k < MASK_WORDS; k++)
    begin
      if (s_axi_araddr == mask_addr(k))
        rd_value = mask[k];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================
  // registers
  assign global_active = reset_ctrl[GLOBAL_RESET_BIT];

  always_comb
  begin
    next_selftest = SELFTEST_DEFAULT;
    next_selftest[TX_DONE_BIT] = tx_selftest.done;
    next_selftest[TX_FAIL_BIT] = tx_selftest.failed;
    next_selftest[TX_CNT_LSB +: CNT_W] = tx_selftest.fail_count;
    next_selftest[RX_DONE_BIT] = rx_selftest.done;
    next_selftest[RX_FAIL_BIT] = rx_selftest.failed;
    next_selftest[RX_CNT_LSB +: CNT_W] = rx_selftest.fail_count;
    next_reset_ctrl = reset_ctrl;
    next_wake_ctrl = wake_ctrl;
    next_crc_low = crc_low;
    next_crc_high = crc_high;
    for (int k = 0; k < MASK_WORDS; k++)
      next_mask[k] = mask[k];
    if (wr_fire)
    begin
      case (aw_addr)
        ADDR_RESET_CTRL: next_reset_ctrl =
          merge(reset_ctrl, w_data, w_strb, RESET_CTRL_WMASK);
        ADDR_WAKE_CTRL: next_wake_ctrl =
          merge(wake_ctrl, w_data, w_strb, WAKE_CTRL_WMASK);
        ADDR_CRC0_LOW: next_crc_low =
          merge(crc_low, w_data, w_strb, FULL_WMASK);
        ADDR_CRC0_HIGH: next_crc_high =
          merge(crc_high, w_data, w_strb, FULL_WMASK);
        default: next_crc_low = crc_low;
      endcase
      for (int k = 0; k < MASK_WORDS; k++)
      begin
        if (aw_addr == mask_addr(k))
          next_mask[k] = merge(mask[k], w_data, w_strb, FULL_WMASK);
      end
    end
    if (global_active)
    begin
      next_wake_ctrl = WAKE_CTRL_DEFAULT;
      next_crc_low = CRC_DEFAULT;
      next_crc_high = CRC_DEFAULT;
      for (int k = 0; k < MASK_WORDS; k++)
        next_mask[k] = MASK_DEFAULT;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      selftest <= SELFTEST_DEFAULT;
      reset_ctrl <= RESET_CTRL_DEFAULT;
      wake_ctrl <= WAKE_CTRL_DEFAULT;
      crc_low <= CRC_DEFAULT;
      crc_high <= CRC_DEFAULT;
      for (int k = 0; k < MASK_WORDS; k++)
        mask[k] <= MASK_DEFAULT;
    end
    else
    begin
      selftest <= next_selftest;
      reset_ctrl <= next_reset_ctrl;
      wake_ctrl <= next_wake_ctrl;
      crc_low <= next_crc_low;
      crc_high <= next_crc_high;
      for (int k = 0; k < MASK_WORDS; k++)
        mask[k] <= next_mask[k];
    end
  end

  // ==========================================================
  // outputs and wakeup frame 0 detector
  assign queue_manager_reset = reset_ctrl[QM_RESET_BIT] ||
                               global_active;
  assign global_soft_reset = global_active;
  assign magic_packet_detect_enable = wake_ctrl[MAGIC_ENABLE_BIT];
  assign wake_pattern_enable = wake_ctrl[WAKE_PATTERNS-1:0];

  generate
    for (genvar g = 0; g < MASK_WORDS; g++)
    begin : g_mask
      assign mask_flat[g*MASK_WORD_BYTES +: MASK_WORD_BYTES] = mask[g];
    end
  endgenerate

  bwr_wake_match u_match0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(global_active),
    .enable(wake_ctrl[0]),
    .rx(rx_byte),
    .byte_mask(mask_flat),
    .expected_crc({crc_high, crc_low}),
    .wake_event(wake_pattern0_event)
  );

  // ==========================================================
  // checks
  chk_tx_selftest_read:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && s_axi_araddr == ADDR_SELFTEST) |=>
        s_axi_rvalid && s_axi_rdata[TX_DONE_BIT:TX_CNT_LSB] ==
        $past({tx_selftest.done, tx_selftest.failed,
               tx_selftest.fail_count}, 2))
    else $error("tx self-test result misread");

  chk_rx_selftest_read:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && s_axi_araddr == ADDR_SELFTEST) |=>
        s_axi_rdata[RX_DONE_BIT:RX_CNT_LSB] ==
        $past({rx_selftest.done, rx_selftest.failed,
               rx_selftest.fail_count}, 2))
    else $error("rx self-test result misread");

  chk_status_reserved_zero:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && s_axi_araddr == ADDR_SELFTEST) |=>
        s_axi_rdata[15:13] == 3'b000 && s_axi_rdata[7:5] == 3'b000)
    else $error("self-test reserved bits not zero");

  chk_qm_reset_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && aw_addr == ADDR_RESET_CTRL && w_strb[0] &&
       w_data[QM_RESET_BIT]) |=> queue_manager_reset [*2])
    else $error("queue manager reset not held");

  chk_reset_level_held:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (global_soft_reset && !(wr_fire && aw_addr == ADDR_RESET_CTRL))
        |=> global_soft_reset)
    else $error("global reset released without write");

  chk_global_clears_wake:
    assert property (@(posedge aclk) disable iff (!aresetn)
      global_soft_reset |=> !magic_packet_detect_enable &&
        wake_pattern_enable == '0 && crc_low == CRC_DEFAULT)
    else $error("global reset left registers set");

  chk_magic_enable_write:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && aw_addr == ADDR_WAKE_CTRL && w_strb[0] &&
       !global_active) |=>
        magic_packet_detect_enable == $past(w_data[MAGIC_ENABLE_BIT]))
    else $error("magic packet enable not written");

  chk_control_reserved:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && (s_axi_araddr == ADDR_RESET_CTRL ||
       s_axi_araddr == ADDR_WAKE_CTRL)) |=>
        s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[6:4] == 3'b000)
    else $error("control reserved bits not zero");

  chk_crc_low_write:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && aw_addr == ADDR_CRC0_LOW && w_strb[1:0] == 2'b11 &&
       !global_active) |=> crc_low == $past(w_data[15:0]))
    else $error("crc low half not written");

  chk_write_answer:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |=> ##1 s_axi_bvalid)
    else $error("write answer late");

endmodule

// *** dv/bwr_regs_tb_top.sv ***
/*
  self-checking bench for the self-test, soft reset and wakeup registers.
  assumes bwr_pkg and bwr_regs are compiled first; bench drives all ports.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module bwr_regs_tb_top
  import bwr_pkg::*;
;
  // ==========================================================
  // bench signals
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  bwr_selftest_t tx_selftest;
  bwr_selftest_t rx_selftest;
  bwr_rx_byte_t rx_byte;
  logic queue_manager_reset, global_soft_reset;
  logic magic_packet_detect_enable, wake_pattern0_event;
  logic [WAKE_PATTERNS-1:0] wake_pattern_enable;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int ev_cnt = 0;

  bwr_regs uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_selftest(tx_selftest),
    .rx_selftest(rx_selftest), .rx_byte(rx_byte),
    .queue_manager_reset(queue_manager_reset),
    .global_soft_reset(global_soft_reset),
    .magic_packet_detect_enable(magic_packet_detect_enable),
    .wake_pattern_enable(wake_pattern_enable),
    .wake_pattern0_event(wake_pattern0_event));

  // ==========================================================
  // clock, watchdog, event counter
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  always @(negedge aclk)
    if (wake_pattern0_event === 1'b1)
      ev_cnt++;

  // ==========================================================
  // bus tasks
  task automatic axi_write(input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    logic aw_go;
    logic w_go;
    logic b_go;
    b_go = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_go)
    begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_go)
        s_axi_awvalid <= 1'b0;
      if (w_go)
        s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a,
    output logic [31:0] d, output logic [1:0] resp);
    logic ar_go;
    logic r_go;
    r_go = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_go)
    begin
      @(negedge aclk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_go)
        s_axi_arvalid <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, s, r);
    `CHK(r, er)
  endtask

  // ==========================================================
  // frame helpers
  function automatic logic [7:0] frame_byte(input int i);
    return 8'(i * 37 + 5);
  endfunction

  function automatic logic [31:0] crc_of(input logic [PATTERN_BYTES-1:0] m);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < PATTERN_BYTES; i++)
      if (m[i])
      begin
        c = c ^ {24'h00_0000, frame_byte(i)};
        for (int b = 0; b < 8; b++)
          c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    return ~c;
  endfunction

  task automatic send_frame(input int n, input int bad);
    for (int i = 0; i < n; i++)
    begin
      rx_byte <= '{valid: 1'b1, last: (i == n - 1),
        data: frame_byte(i) ^ ((i == bad) ? 8'h01 : 8'h00)};
      @(posedge aclk);
    end
    rx_byte <= '{valid: 1'b0, last: 1'b0, data: 8'hff};
  endtask

  // ==========================================================
  // scenarios
  task automatic t_defaults();
    rd_chk(ADDR_SELFTEST, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_RESET_CTRL, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_WAKE_CTRL, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_CRC0_LOW, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_CRC0_HIGH, 32'h0000_0000, RESP_OKAY);
    rd_chk(8'h04, 32'h0000_0000, RESP_SLVERR);
    wr(8'h04, 32'h0000_ffff, 4'hf, RESP_SLVERR);
    `CHK(queue_manager_reset, 1'b0)
  endtask

  task automatic t_selftest();
    tx_selftest <= '{done: 1'b1, failed: 1'b1, fail_count: 3'h5};
    rx_selftest <= '{done: 1'b1, failed: 1'b0, fail_count: 3'h2};
    repeat (2) @(posedge aclk);
    rd_chk(ADDR_SELFTEST, 32'h0000_1d12, RESP_OKAY);
    tx_selftest <= '{done: 1'b0, failed: 1'b0, fail_count: 3'h7};
    rx_selftest <= '{done: 1'b0, failed: 1'b1, fail_count: 3'h0};
    repeat (2) @(posedge aclk);
    rd_chk(ADDR_SELFTEST, 32'h0000_0708, RESP_OKAY);
    wr(ADDR_SELFTEST, 32'h0000_ffff, 4'hf, RESP_OKAY);
    rd_chk(ADDR_SELFTEST, 32'h0000_0708, RESP_OKAY);
  endtask

  task automatic t_wake_ctrl();
    for (int b = 0; b < 8; b++)
    begin
      wr(ADDR_WAKE_CTRL, 32'h0000_ff00 | (32'h1 << b), 4'h3, RESP_OKAY);
      rd_chk(ADDR_WAKE_CTRL, (32'h1 << b) & 32'h0000_008f, RESP_OKAY);
      `CHK(magic_packet_detect_enable, (b == 7))
      `CHK(wake_pattern_enable, 4'((32'h1 << b) & 32'h0000_000f))
    end
  endtask

  task automatic t_crc();
    wr(ADDR_CRC0_LOW, 32'h0000_1234, 4'h1, RESP_OKAY);
    rd_chk(ADDR_CRC0_LOW, 32'h0000_0034, RESP_OKAY);
    wr(ADDR_CRC0_HIGH, 32'hffff_abcd, 4'hf, RESP_OKAY);
    rd_chk(ADDR_CRC0_HIGH, 32'h0000_abcd, RESP_OKAY);
  endtask

  task automatic t_match();
    logic [PATTERN_BYTES-1:0] m;
    logic [31:0] c;
    m = {16'h8000, 16'h00f0, 16'h0000, 16'h8001};
    c = crc_of(m);
    for (int k = 0; k < MASK_WORDS; k++)
      wr(ADDR_MASK0 + 8'(k) * ADDR_MASK_STEP, 32'(m[16*k +: 16]), 4'h3,
        RESP_OKAY);
    wr(ADDR_CRC0_LOW, {16'h0000, c[15:0]}, 4'h3, RESP_OKAY);
    wr(ADDR_CRC0_HIGH, {16'h0000, c[31:16]}, 4'h3, RESP_OKAY);
    wr(ADDR_WAKE_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
    ev_cnt = 0;
    send_frame(70, -1);
    @(negedge aclk);
    `CHK(wake_pattern0_event, 1'b1)
    repeat (3) @(posedge aclk);
    `CHK(ev_cnt, 1)
    ev_cnt = 0;
    send_frame(70, 15);
    repeat (3) @(posedge aclk);
    `CHK(ev_cnt, 0)
    send_frame(64, 63);
    repeat (3) @(posedge aclk);
    `CHK(ev_cnt, 0)
    send_frame(64, -1);
    repeat (3) @(posedge aclk);
    `CHK(ev_cnt, 1)
    ev_cnt = 0;
    wr(ADDR_WAKE_CTRL, 32'h0000_0000, 4'h1, RESP_OKAY);
    send_frame(70, -1);
    repeat (3) @(posedge aclk);
    `CHK(ev_cnt, 0)
  endtask

  task automatic t_soft_reset();
    wr(ADDR_WAKE_CTRL, 32'h0000_008f, 4'h1, RESP_OKAY);
    wr(ADDR_RESET_CTRL, 32'h0000_0002, 4'h3, RESP_OKAY);
    `CHK({queue_manager_reset, global_soft_reset}, 2'b10)
    rd_chk(ADDR_WAKE_CTRL, 32'h0000_008f, RESP_OKAY);
    wr(ADDR_RESET_CTRL, 32'h0000_ffff, 4'h3, RESP_OKAY);
    rd_chk(ADDR_RESET_CTRL, 32'h0000_0003, RESP_OKAY);
    `CHK({queue_manager_reset, global_soft_reset}, 2'b11)
    rd_chk(ADDR_WAKE_CTRL, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_CRC0_HIGH, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_MASK0, 32'h0000_0000, RESP_OKAY);
    `CHK(magic_packet_detect_enable, 1'b0)
    wr(ADDR_RESET_CTRL, 32'h0000_0000, 4'h3, RESP_OKAY);
    `CHK({queue_manager_reset, global_soft_reset}, 2'b00)
  endtask

  // ==========================================================
  // main sequence and verdict
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    aresetn <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'h0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= '0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    tx_selftest <= '0;
    rx_selftest <= '0;
    rx_byte <= '{valid: 1'b0, last: 1'b0, data: 8'hff};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults();
    t_selftest();
    t_wake_ctrl();
    t_crc();
    t_match();
    t_soft_reset();
    finish_test();
  end
endmodule
